//--- common/adc_scan_pkg.sv
// Package: register map, field layout, input codes and sequencer states
package adc_scan_pkg;

  // Register byte addresses
  localparam logic [7:0] SOFTWARE_TRIGGER_ADDR = 8'h0c;
  localparam logic [7:0] INPUT_CONTROL_ADDR    = 8'h10;
  localparam logic [7:0] EVENT_CONTROL_ADDR    = 8'h14;
  localparam logic [7:0] SCAN_STATUS_ADDR      = 8'h18;

  // Reset values and writable mask
  localparam logic [7:0]  SOFTWARE_TRIGGER_RESET = 8'h00;
  localparam logic [31:0] INPUT_CONTROL_RESET    = 32'h0000_0000;
  localparam logic [31:0] INPUT_CONTROL_MASK     = 32'h0fff_1f1f;
  localparam logic [1:0]  EVENT_CONTROL_RESET    = 2'h0;

  // Field positions
  localparam int TRIG_FLUSH_BIT  = 0;
  localparam int TRIG_START_BIT  = 1;
  localparam int POS_LSB         = 0;
  localparam int NEG_LSB         = 8;
  localparam int SCAN_LSB        = 16;
  localparam int OFFSET_LSB      = 20;
  localparam int GAIN_LSB        = 24;
  localparam int EV_START_BIT    = 0;
  localparam int EV_SYNC_BIT     = 1;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_FLUSH_BIT  = 1;
  localparam int STAT_POS_LSB    = 8;

  // Gain codes
  localparam logic [3:0] GAIN_1X   = 4'h0;
  localparam logic [3:0] GAIN_16X  = 4'h4;
  localparam logic [3:0] HALF_GAIN = 4'hf;

  // Negative input codes
  localparam logic [4:0] NEG_PIN_LAST     = 5'h07;
  localparam logic [4:0] NEG_GND          = 5'h18;
  localparam logic [4:0] IO_GROUND_INPUT  = 5'h19;

  // Positive input codes
  localparam logic [4:0] POS_PIN_LAST     = 5'h13;
  localparam logic [4:0] POS_TEMP         = 5'h18;
  localparam logic [4:0] POS_DAC          = 5'h1c;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_CONV  = 2'b01,
    SEQ_FLUSH = 2'b10
  } seq_state_e;

  // Gain code is defined: 1x..16x or one-half
  function automatic logic gain_code_ok(input logic [3:0] code);
    return (code <= GAIN_16X) || (code == HALF_GAIN);
  endfunction

  // Negative code is defined: pins 0..7, internal or I/O ground
  function automatic logic neg_code_ok(input logic [4:0] code);
    return (code <= NEG_PIN_LAST) || (code == NEG_GND) ||
           (code == IO_GROUND_INPUT);
  endfunction

  // Positive code is defined: pins 0..19 or internal sources
  function automatic logic pos_code_ok(input logic [4:0] code);
    return (code <= POS_PIN_LAST) ||
           ((code >= POS_TEMP) && (code <= POS_DAC));
  endfunction

endpackage

//--- common/conv_if.sv
// Interface between register front end and conversion sequencer
`timescale 1ns/1ns
`default_nettype none
interface conv_if;
  logic start_req;   // Start bit pending
  logic flush_req;   // Flush bit pending
  logic started;     // Conversion begun, one cycle
  logic flush_done;  // Flush completed, one cycle
  logic conv_done;   // Conversion completed, one cycle
  logic busy;        // Conversion in progress
  logic clk_en;      // Converter clock tick

  modport ctrl (output start_req, flush_req,
                input  started, flush_done, conv_done, busy, clk_en);
  modport seq  (input  start_req, flush_req,
                output started, flush_done, conv_done, busy, clk_en);
endinterface
`default_nettype wire

//--- core/conv_sequencer.sv
// Converter clock divider and conversion/flush sequencer
`timescale 1ns/1ns
`default_nettype none
module conv_sequencer
  import adc_scan_pkg::*;
#(
  parameter int CLK_DIV    = 4,
  parameter int CONV_TICKS = 12
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Front end
  conv_if.seq       cv
);
  localparam int DW = (CLK_DIV > 1) ? $clog2(CLK_DIV) : 1;
  localparam int TW = (CONV_TICKS > 1) ? $clog2(CONV_TICKS) : 1;
  localparam logic [DW-1:0] DIV_LAST  = DW'(CLK_DIV - 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(CONV_TICKS - 1);

  seq_state_e    state_r,  state_nxt;
  logic [DW-1:0] div_r,    div_nxt;
  logic [TW-1:0] ticks_r,  ticks_nxt;
  logic          resume_r, resume_nxt;

  // Converter clock enable from the divider
  assign cv.clk_en = (div_r == DIV_LAST);
  assign cv.busy   = (state_r == SEQ_CONV);

  // Next state, divider and conversion timing
  always_comb begin
    state_nxt     = state_r;
    div_nxt       = cv.clk_en ? '0 : div_r + 1'b1;
    ticks_nxt     = ticks_r;
    resume_nxt    = resume_r;
    cv.started    = 1'b0;
    cv.flush_done = 1'b0;
    cv.conv_done  = 1'b0;
    case (state_r)
      SEQ_IDLE: begin
        if (cv.flush_req) begin
          state_nxt  = SEQ_FLUSH;
          div_nxt    = '0;
          resume_nxt = 1'b0;
        end else if (cv.start_req && cv.clk_en) begin
          state_nxt  = SEQ_CONV;
          ticks_nxt  = '0;
          cv.started = 1'b1;
        end
      end
      SEQ_CONV: begin
        if (cv.flush_req) begin
          state_nxt  = SEQ_FLUSH;
          div_nxt    = '0;
          resume_nxt = 1'b1;
        end else if (cv.clk_en) begin
          if (ticks_r == TICK_LAST) begin
            state_nxt    = SEQ_IDLE;
            cv.conv_done = 1'b1;
          end else begin
            ticks_nxt = ticks_r + 1'b1;
          end
        end
      end
      SEQ_FLUSH: begin
        cv.flush_done = 1'b1;
        resume_nxt    = 1'b0;
        if (resume_r || cv.start_req) begin
          state_nxt  = SEQ_CONV;
          ticks_nxt  = '0;
          cv.started = 1'b1;
        end else begin
          state_nxt = SEQ_IDLE;
        end
      end
      default: begin
        state_nxt = SEQ_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r  <= SEQ_IDLE;
      div_r    <= '0;
      ticks_r  <= '0;
      resume_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      div_r    <= div_nxt;
      ticks_r  <= ticks_nxt;
      resume_r <= resume_nxt;
    end
  end
endmodule
`default_nettype wire

//--- core/adc_trigger_scan.sv
// Converter trigger and input scan control with AXI4-Lite registers
//
// What this block does
// - Writing one to start launches one conversion; zero does nothing.
// - Start bit clears when the requested conversion has begun.
// - Writing start while it is still set is ignored, nothing queued.
// - Writing one to flush flushes the pipeline; zero does nothing.
// - Flush restarts converter clock next edge and aborts running conversions.
// - Flush bit self-clears after flush; a pending conversion then restarts.
// - Gain field selects 1x..16x for 0..4, one-half for 0xF.
// - Scanning is active whenever the scan count field is nonzero.
// - Converted positive input is positive select plus scan offset.
// - While scanning, offset increments by one after each conversion, wrapping to zero after count.
// - Scan covers count plus one consecutive inputs from select plus offset.
// - Negative select: pins 0..7, internal ground 0x18, I/O ground 0x19.
// - Positive select codes 0x00..0x08 pick pin equal to the code.
// - Positive 0x09..0x13 pins 9..19; 0x18..0x1C internal sources.
// - Enabled start event starts; enabled sync event flushes then starts.
`timescale 1ns/1ns
`default_nettype none
module adc_trigger_scan
  import adc_scan_pkg::*;
#(
  parameter int CLK_DIV    = 4,
  parameter int CONV_TICKS = 12
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // Event inputs, same clock domain
  input  wire logic       start_event,
  input  wire logic       sync_event,
  // Converter control
  output logic            conv_clk_en,
  output logic            conv_running,
  output logic            conv_done,
  output logic [4:0]      converted_pos_input,
  output logic [4:0]      negative_input_select,
  output logic [3:0]      gain_code,
  output logic            half_gain,
  output logic [2:0]      gain_shift,
  output logic            input_sel_valid
);

  conv_if cv ();

  // Write channel holding
  logic        aw_held_r, aw_held_nxt;
  logic [7:0]  awaddr_r,  awaddr_nxt;
  logic        w_held_r,  w_held_nxt;
  logic [31:0] wdata_r,   wdata_nxt;
  logic [3:0]  wstrb_r,   wstrb_nxt;
  logic        bvalid_r,  bvalid_nxt;
  logic [1:0]  bresp_r,   bresp_nxt;
  // Read channel
  logic        rvalid_r,  rvalid_nxt;
  logic [31:0] rdata_r,   rdata_nxt;
  logic [1:0]  rresp_r,   rresp_nxt;
  // Register contents
  logic        start_r,   start_nxt;
  logic        flush_r,   flush_nxt;
  logic [31:0] inctl_r,   inctl_nxt;
  logic [1:0]  evctl_r,   evctl_nxt;
  logic [4:0]  pos_lat_r, pos_lat_nxt;
  // Decoded fields
  logic [4:0]  positive_input_select;
  logic [3:0]  scan_cnt;
  logic [3:0]  scan_off;
  logic [4:0]  pos_now;
  logic        scan_on;
  logic [31:0] merged;
  logic [31:0] status_word;

  // Field views of the input control register
  assign positive_input_select   = inctl_r[POS_LSB +: 5];
  assign scan_cnt = inctl_r[SCAN_LSB +: 4];
  assign scan_off = inctl_r[OFFSET_LSB +: 4];
  assign scan_on  = (scan_cnt != 4'h0);
  assign pos_now  = 5'(positive_input_select + {1'b0, scan_off});
  assign status_word = {19'h0, pos_lat_r, 6'h0, flush_r, cv.busy};

  // Handshake outputs
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Sequencer requests and converter status
  assign cv.start_req = start_r;
  assign cv.flush_req = flush_r;
  assign conv_clk_en  = cv.clk_en;
  assign conv_running = cv.busy;
  assign conv_done    = cv.conv_done;

  conv_sequencer #(
    .CLK_DIV    (CLK_DIV),
    .CONV_TICKS (CONV_TICKS)
  ) u_seq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cv      (cv.seq)
  );

  // Bus slave and register next values
  always_comb begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt  = awaddr_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    start_nxt   = start_r;
    flush_nxt   = flush_r;
    inctl_nxt   = inctl_r;
    evctl_nxt   = evctl_r;
    pos_lat_nxt = pos_lat_r;
    merged      = inctl_r;
    // Hardware side effects
    if (cv.started) begin
      start_nxt   = 1'b0;
      pos_lat_nxt = pos_now;
    end
    if (cv.flush_done) begin
      flush_nxt = 1'b0;
    end
    if (cv.conv_done && scan_on) begin
      if (scan_off >= scan_cnt) begin
        inctl_nxt[OFFSET_LSB +: 4] = 4'h0;
      end else begin
        inctl_nxt[OFFSET_LSB +: 4] = scan_off + 4'h1;
      end
    end
    // Event inputs
    if (evctl_r[EV_START_BIT] && start_event && !start_r) begin
      start_nxt = 1'b1;
    end
    if (evctl_r[EV_SYNC_BIT] && sync_event) begin
      flush_nxt = 1'b1;
      start_nxt = 1'b1;
    end
    // Write address and data capture
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Perform a held write
    if (aw_held_r && w_held_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      case ({awaddr_r[7:2], 2'b00})
        SOFTWARE_TRIGGER_ADDR: begin
          if (wstrb_r[0]) begin
            if (wdata_r[TRIG_START_BIT] && !start_r) begin
              start_nxt = 1'b1;
            end
            if (wdata_r[TRIG_FLUSH_BIT]) begin
              flush_nxt = 1'b1;
            end
          end
        end
        INPUT_CONTROL_ADDR: begin
          for (int b = 0; b < 4; b++) begin
            if (wstrb_r[b]) begin
              merged[8*b +: 8] = wdata_r[8*b +: 8];
            end
          end
          inctl_nxt = merged & INPUT_CONTROL_MASK;
        end
        EVENT_CONTROL_ADDR: begin
          if (wstrb_r[0]) begin
            evctl_nxt = wdata_r[1:0];
          end
        end
        SCAN_STATUS_ADDR: begin
          bresp_nxt = RESP_OKAY;
        end
        default: begin
          bresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    // Read
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        SOFTWARE_TRIGGER_ADDR: rdata_nxt = {30'h0, start_r, flush_r};
        INPUT_CONTROL_ADDR:    rdata_nxt = inctl_r;
        EVENT_CONTROL_ADDR:    rdata_nxt = {30'h0, evctl_r};
        SCAN_STATUS_ADDR:      rdata_nxt = status_word;
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  // Bus and register state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 8'h00;
      w_held_r  <= 1'b0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= RESP_OKAY;
      start_r   <= SOFTWARE_TRIGGER_RESET[TRIG_START_BIT];
      flush_r   <= SOFTWARE_TRIGGER_RESET[TRIG_FLUSH_BIT];
      inctl_r   <= INPUT_CONTROL_RESET;
      evctl_r   <= EVENT_CONTROL_RESET;
      pos_lat_r <= 5'h00;
    end else begin
      aw_held_r <= aw_held_nxt;
      awaddr_r  <= awaddr_nxt;
      w_held_r  <= w_held_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      start_r   <= start_nxt;
      flush_r   <= flush_nxt;
      inctl_r   <= inctl_nxt;
      evctl_r   <= evctl_nxt;
      pos_lat_r <= pos_lat_nxt;
    end
  end

  // Input selection and gain outputs, next values
  logic [4:0] cpos_nxt;
  logic [4:0] neg_nxt;
  logic [3:0] gain_nxt;
  logic       half_nxt;
  logic [2:0] shift_nxt;
  logic       valid_nxt;
  always_comb begin
    cpos_nxt  = pos_lat_r;
    neg_nxt   = inctl_r[NEG_LSB +: 5];
    gain_nxt  = inctl_r[GAIN_LSB +: 4];
    half_nxt  = (gain_nxt == HALF_GAIN);
    shift_nxt = (gain_nxt <= GAIN_16X) ? gain_nxt[2:0] : 3'h0;
    valid_nxt = pos_code_ok(cpos_nxt) &&
                neg_code_ok(neg_nxt) &&
                gain_code_ok(gain_nxt);
  end

  // Registered converter selection outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converted_pos_input   <= 5'h00;
      negative_input_select <= 5'h00;
      gain_code             <= GAIN_1X;
      half_gain             <= 1'b0;
      gain_shift            <= 3'h0;
      input_sel_valid       <= 1'b0;
    end else begin
      converted_pos_input   <= cpos_nxt;
      negative_input_select <= neg_nxt;
      gain_code             <= gain_nxt;
      half_gain             <= half_nxt;
      gain_shift            <= shift_nxt;
      input_sel_valid       <= valid_nxt;
    end
  end

endmodule
`default_nettype wire

//--- sim/analog_source_model.sv
// Analog source side: logs the input used by each finished conversion
`timescale 1ns/1ns
`default_nettype none
module analog_source_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Converter control seen by the sources
  input  wire logic       conv_done,
  input  wire logic [4:0] converted_pos_input
);
  int         n_done;
  logic [4:0] last_in;

  // Count finished conversions and keep the input each one sampled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_done  <= 0;
      last_in <= 5'h00;
    end else if (conv_done) begin
      n_done  <= n_done + 1;
      last_in <= converted_pos_input;
    end
  end
endmodule
`default_nettype wire

//--- sim/adc_trigger_scan_chk.sv
// Checker: bus handshake and converter control properties at the top ports
`timescale 1ns/1ns
`default_nettype none
module adc_trigger_scan_chk #(
  parameter int CLK_DIV    = 4,
  parameter int CONV_TICKS = 12
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bus handshakes
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  // Converter control
  input  wire logic        conv_clk_en,
  input  wire logic        conv_running,
  input  wire logic        conv_done,
  input  wire logic [3:0]  gain_code,
  input  wire logic        half_gain,
  input  wire logic [2:0]  gain_shift
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Write address and data taken together, then response two edges on
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_resp;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  a_write_latency: assert property (s_wr_take |=> s_wr_resp)
    else $error("write response not two edges after take");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accept");
  a_write_block: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("new write accepted while response pending");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data not one edge after take");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accept");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_tick_gap: assert property (conv_clk_en |=> !conv_clk_en)
    else $error("converter clock ticks back to back");
  a_done_on_tick: assert property (conv_done |->
    conv_clk_en && conv_running)
    else $error("conversion end off tick or while idle");
  a_half_gain: assert property (half_gain == (gain_code == 4'hf))
    else $error("half gain flag disagrees with gain code");
  a_gain_shift: assert property (gain_shift ==
    ((gain_code <= 4'h4) ? gain_code[2:0] : 3'h0))
    else $error("gain shift disagrees with gain code");
endmodule

bind adc_trigger_scan adc_trigger_scan_chk #(
  .CLK_DIV(CLK_DIV), .CONV_TICKS(CONV_TICKS)
) u_adc_trigger_scan_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .conv_clk_en, .conv_running, .conv_done, .gain_code,
  .half_gain, .gain_shift
);
`default_nettype wire

//--- sim/tb_adc_trigger_scan.sv
// Testbench: register access, scan sequencing, flush and event triggers
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, g, e); \
    end \
  end
module tb_adc_trigger_scan;
  import adc_scan_pkg::*;
  localparam int CLK_DIV    = 4;
  localparam int CONV_TICKS = 2;

  // Design ports and bench state
  logic        aclk, aresetn, start_event, sync_event;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, gain_code, g;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, conv_clk_en, conv_running;
  logic        conv_done, half_gain, input_sel_valid;
  logic [4:0]  converted_pos_input, negative_input_select;
  logic [2:0]  gain_shift;
  logic [12:0] vld = 13'h173f; // Positive part is the latched input, pin 0
  logic [31:0] cfg [13] = '{32'h0000_0000, 32'h0100_0000, 32'h0200_0000,
    32'h0300_0000, 32'h0400_0000, 32'h0f00_0000, 32'h0500_0000,
    32'h0e00_0000, 32'h0000_0708, 32'h0000_1813, 32'h0000_191c,
    32'h0000_0800, 32'h0000_0014};
  int          n_errors = 0;
  int          checked = 0;
  int          n, i, k;

  adc_trigger_scan #(.CLK_DIV(CLK_DIV), .CONV_TICKS(CONV_TICKS))
  u_adc_trigger_scan (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .start_event, .sync_event,
    .conv_clk_en, .conv_running, .conv_done, .converted_pos_input,
    .negative_input_select, .gain_code, .half_gain, .gain_shift,
    .input_sel_valid
  );

  analog_source_model u_model (
    .aclk, .aresetn, .conv_done, .converted_pos_input
  );

  // Verdict and end of run
  task automatic end_sim;
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic timed_out;
    n_errors++;
    $display("unexpected at %0t: wait timed out", $time);
    end_sim;
  endtask

  // Bus write: address and data offered together, each dropped when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    int j;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
        break;
      end
    end
    if (j == 50) timed_out;
  endtask

  // Bus read with expected data and response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int j;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
        break;
      end
    end
    if (j == 50) timed_out;
  endtask

  // Wait until the sources have seen the given number of conversions
  task automatic wait_done(input int t);
    int j;
    for (j = 0; j < 300 && u_model.n_done < t; j++) @(posedge aclk);
    if (j == 300) timed_out;
  endtask

  // One software-started conversion, checking the input it used
  task automatic conv_once(input logic [4:0] e);
    int c;
    c = u_model.n_done;
    axi_write(SOFTWARE_TRIGGER_ADDR, 32'h2, RESP_OKAY);
    wait_done(c + 1);
    `CHK(u_model.last_in, e)
  endtask

  // One-cycle event pulse
  task automatic pulse(input bit sync);
    @(posedge aclk);
    if (sync) sync_event <= 1'b1;
    else start_event <= 1'b1;
    @(posedge aclk);
    start_event <= 1'b0;
    sync_event  <= 1'b0;
  endtask

  // Peripheral clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Main sequence
  initial begin
    {aresetn, start_event, sync_event, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, unmapped place, writable fields
    rd_chk(SOFTWARE_TRIGGER_ADDR, 32'h0, RESP_OKAY);
    rd_chk(INPUT_CONTROL_ADDR, 32'h0, RESP_OKAY);
    rd_chk(8'h20, 32'h0, RESP_SLVERR);
    axi_write(8'h20, 32'h1, RESP_SLVERR);
    axi_write(INPUT_CONTROL_ADDR, 32'hffff_ffff, RESP_OKAY);
    rd_chk(INPUT_CONTROL_ADDR, 32'h0fff_1f1f, RESP_OKAY);
    // Gain, negative and positive code table
    for (i = 0; i < 13; i++) begin
      g = cfg[i][27:24];
      axi_write(INPUT_CONTROL_ADDR, cfg[i], RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK(gain_code, g)
      `CHK(half_gain, g == HALF_GAIN)
      `CHK(gain_shift, (g <= GAIN_16X) ? g[2:0] : 3'h0)
      `CHK(negative_input_select, cfg[i][12:8])
      `CHK(input_sel_valid, vld[i])
    end
    // Scan of three inputs from 3, kept within existing pins
    axi_write(INPUT_CONTROL_ADDR, 32'h0002_0003, RESP_OKAY);
    conv_once(5'h03);
    rd_chk(INPUT_CONTROL_ADDR, 32'h0012_0003, RESP_OKAY);
    rd_chk(SOFTWARE_TRIGGER_ADDR, 32'h0, RESP_OKAY);
    conv_once(5'h04);
    conv_once(5'h05);
    rd_chk(INPUT_CONTROL_ADDR, 32'h0002_0003, RESP_OKAY);
    conv_once(5'h03);
    axi_write(INPUT_CONTROL_ADDR, 32'h0011_0005, RESP_OKAY);
    conv_once(5'h06);
    axi_write(INPUT_CONTROL_ADDR, 32'h0000_0002, RESP_OKAY);
    conv_once(5'h02);
    rd_chk(INPUT_CONTROL_ADDR, 32'h0000_0002, RESP_OKAY);
    // Zero writes and idle flush start nothing
    n = u_model.n_done;
    axi_write(SOFTWARE_TRIGGER_ADDR, 32'h0, RESP_OKAY);
    axi_write(SOFTWARE_TRIGGER_ADDR, 32'h1, RESP_OKAY);
    repeat (40) @(posedge aclk);
    `CHK(u_model.n_done, n)
    rd_chk(SOFTWARE_TRIGGER_ADDR, 32'h0, RESP_OKAY);
    // Flush in mid-conversion: aborted, then redone once
    axi_write(SOFTWARE_TRIGGER_ADDR, 32'h2, RESP_OKAY);
    for (k = 0; k < 50 && conv_running !== 1'b1; k++) @(posedge aclk);
    if (k == 50) timed_out;
    axi_write(SOFTWARE_TRIGGER_ADDR, 32'h1, RESP_OKAY);
    wait_done(n + 1);
    repeat (40) @(posedge aclk);
    `CHK(u_model.n_done, n + 1)
    rd_chk(SOFTWARE_TRIGGER_ADDR, 32'h0, RESP_OKAY);
    // Event inputs, disabled then enabled one at a time
    axi_write(EVENT_CONTROL_ADDR, 32'h0, RESP_OKAY);
    pulse(1'b0);
    pulse(1'b1);
    repeat (40) @(posedge aclk);
    `CHK(u_model.n_done, n + 1)
    axi_write(EVENT_CONTROL_ADDR, 32'h1, RESP_OKAY);
    pulse(1'b0);
    wait_done(n + 2);
    axi_write(EVENT_CONTROL_ADDR, 32'h2, RESP_OKAY);
    pulse(1'b0);
    repeat (40) @(posedge aclk);
    `CHK(u_model.n_done, n + 2)
    pulse(1'b1);
    wait_done(n + 3);
    `CHK(u_model.last_in, 5'h02)
    // Reserved positive code converted: flagged, and shown in status
    axi_write(INPUT_CONTROL_ADDR, 32'h0000_0014, RESP_OKAY);
    conv_once(5'h14);
    `CHK(input_sel_valid, 1'b0)
    rd_chk(SCAN_STATUS_ADDR, 32'h0000_1400, RESP_OKAY);
    end_sim;
  end
endmodule
`default_nettype wire
